// ===== hdl/nvbc_ctrl.sv
// controller for the 32x8 nonvolatile byte store with cpu register access
// assumes the cpu presents single-cycle register reads and writes
`timescale 1ns/1ps
`default_nettype none
module nvbc_ctrl
  import nvbc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // direct bank-0 registers
  input wire logic i_addr_wr,
  input wire logic i_data_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_nv_byte_address,
  output logic [7:0] o_nv_byte_data,
  // bank select and second indirect pointer
  input wire logic i_bank_wr,
  input wire logic i_pointer_wr,
  output logic [7:0] o_bank_select,
  output logic [7:0] o_indirect_pointer_second,
  // second indirect window
  input wire logic i_window_wr,
  input wire logic i_window_rd,
  output logic [7:0] o_indirect_window_second,
  output logic o_window_hit,
  // interrupt controls
  input wire logic i_nv_irq_enable,
  input wire logic i_mf_irq_enable,
  input wire logic i_global_irq_enable,
  input wire logic i_stack_full,
  input wire logic i_irq_serviced,
  input wire logic i_nv_flag_clear,
  output logic o_nv_irq_flag,
  output logic o_mf_irq_flag,
  output logic o_irq_request,
  output logic o_vector_take,
  // status
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    nvbc_state_type state;
    logic [NVBC_AW-1:0] addr;
    logic [7:0] data;
    logic bank;
    logic [7:0] pointer;
    logic write_permit;
    logic write_start;
    logic read_permit;
    logic read_start;
    logic permit_fresh;
    logic [15:0] count;
    logic nv_flag;
    logic mf_flag;
    logic [NVBC_DEPTH-1:0][7:0] mem;
  } nvbc_regs_type;

  nvbc_regs_type r;
  nvbc_regs_type next_r;
  logic tick;

  nvbc_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .o_tick(tick)
  );

  function automatic logic [7:0] ctrl_byte(input nvbc_regs_type s);
    ctrl_byte = {4'h0, s.write_permit, s.write_start, s.read_permit, s.read_start}; // R5
  endfunction : ctrl_byte

  logic ctrl_hit;
  logic [7:0] wbits;
  logic write_go;
  logic read_go;
  logic cycle_end;

  ////////////////////////////////////////////////////////////////////////
  // the control byte is visible only via the bank-1 window at 40H
  assign ctrl_hit = r.bank == NVBC_CTRL_BANK && r.pointer == NVBC_CTRL_OFFSET; // R3
  assign wbits = i_wdata;

  always_comb begin
    next_r = r;
    write_go = 1'b0;
    read_go = 1'b0;
    cycle_end = 1'b0;
    if (i_bank_wr) begin
      next_r.bank = i_wdata[0];
    end
    if (i_pointer_wr) begin
      next_r.pointer = i_wdata;
    end
    if (i_addr_wr && r.state == NVBC_IDLE) begin
      next_r.addr = i_wdata[NVBC_AW-1:0]; // R2
    end
    if (i_data_wr && r.state == NVBC_IDLE) begin
      next_r.data = i_wdata; // R21
    end
    // control writes; start bits only rise, hardware owns their fall
    if (i_window_wr && ctrl_hit && r.state == NVBC_IDLE) begin
      next_r.write_permit = wbits[NVBC_BIT_WPERMIT];
      next_r.read_permit = wbits[NVBC_BIT_RPERMIT];
      next_r.permit_fresh = wbits[NVBC_BIT_WPERMIT] && !r.write_permit;
      // write start counts only right after the permit was raised
      if (wbits[NVBC_BIT_WSTART] && r.write_permit && r.permit_fresh && !wbits[NVBC_BIT_RSTART]) begin // R6 R22 R13
        write_go = 1'b1;
      end else if (wbits[NVBC_BIT_RSTART] && r.read_permit && !wbits[NVBC_BIT_WSTART]) begin // R8 R11
        read_go = 1'b1;
      end
    end else if (i_window_wr && ctrl_hit) begin
      next_r.permit_fresh = 1'b0;
    end
    if (write_go) begin
      next_r.write_start = 1'b1;
      next_r.state = NVBC_WRITE;
      next_r.count = 16'(NVBC_WRITE_CYCLES);
    end
    if (read_go) begin
      next_r.read_start = 1'b1;
      next_r.state = NVBC_READ;
      next_r.count = 16'(NVBC_READ_CYCLES);
    end
    unique case (r.state)
      NVBC_IDLE: begin
      end
      NVBC_READ: begin
        if (r.count > 16'h0001) begin
          next_r.count = r.count - 16'h0001;
        end else begin
          next_r.data = r.mem[r.addr]; // R9 R10 R1
          next_r.read_start = 1'b0; // R9
          next_r.state = NVBC_IDLE;
          cycle_end = 1'b1;
        end
      end
      NVBC_WRITE: begin
        // the count only moves on the free-running tick
        if (tick && r.count > 16'h0001) begin // R12
          next_r.count = r.count - 16'h0001;
        end else if (tick) begin
          next_r.mem[r.addr] = r.data; // R1
          next_r.write_start = 1'b0; // R7
          next_r.state = NVBC_IDLE;
          cycle_end = 1'b1;
        end
      end
      default: begin
        next_r.state = NVBC_IDLE;
      end
    endcase
    // set wins over clear for both flags
    if (i_nv_flag_clear) begin
      next_r.nv_flag = 1'b0; // R20
    end
    if (i_irq_serviced) begin
      next_r.mf_flag = 1'b0; // R20
    end
    if (cycle_end) begin
      next_r.nv_flag = 1'b1; // R17
      next_r.mf_flag = 1'b1; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array contents survive reset, as a real nonvolatile store would
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r.state <= NVBC_IDLE;
      r.addr <= '0; // R2
      r.data <= NVBC_RESET_BYTE; // R21
      r.bank <= 1'b0; // R16
      r.pointer <= 8'h00;
      r.write_permit <= 1'b0; // R16
      r.write_start <= 1'b0;
      r.read_permit <= 1'b0;
      r.read_start <= 1'b0;
      r.permit_fresh <= 1'b0;
      r.count <= 16'h0000;
      r.nv_flag <= 1'b0;
      r.mf_flag <= 1'b0;
    end else if (i_ce) begin
      r.state <= next_r.state;
      r.addr <= next_r.addr;
      r.data <= next_r.data;
      r.bank <= next_r.bank;
      r.pointer <= next_r.pointer;
      r.write_permit <= next_r.write_permit;
      r.write_start <= next_r.write_start;
      r.read_permit <= next_r.read_permit;
      r.read_start <= next_r.read_start;
      r.permit_fresh <= next_r.permit_fresh;
      r.count <= next_r.count;
      r.nv_flag <= next_r.nv_flag;
      r.mf_flag <= next_r.mf_flag;
      r.mem <= next_r.mem;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_nv_byte_address = {3'h0, r.addr}; // R2
  assign o_nv_byte_data = r.data;
  assign o_bank_select = {7'h00, r.bank};
  assign o_indirect_pointer_second = r.pointer;
  assign o_window_hit = ctrl_hit && (i_window_rd || i_window_wr);
  assign o_indirect_window_second = ctrl_hit ? ctrl_byte(r) : 8'h00; // R3
  assign o_nv_irq_flag = r.nv_flag;
  assign o_mf_irq_flag = r.mf_flag;
  assign o_irq_request = r.nv_flag && i_nv_irq_enable && i_mf_irq_enable; // R18
  assign o_vector_take = o_irq_request && r.mf_flag && i_global_irq_enable && !i_stack_full; // R19
  assign o_busy = r.state != NVBC_IDLE;
endmodule : nvbc_ctrl
`default_nettype wire

// ===== hdl/nvbc_pkg.sv
// package for the byte-wide nonvolatile store controller
// assumes a single core clock domain and a simple cpu-side register port
//
// Overview of operation
// R1: thirty-two byte store, reached one byte at a time via registers only.
// R2: address register keeps five bits, upper three read zero, reset zero.
// R3: control register lives at 40H of bank 1, indirect window only.
// R4: software loads second pointer with 40H and bank select with 01H first.
// R5: control bits: write permit 3, write start 2, read permit 1, read start 0.
// R6: write start with write permit begins write cycle; otherwise ignored.
// R7: write start clears itself when the write cycle ends.
// R8: read start with read permit begins read at current address; otherwise ignored.
// R9: read end clears read start and loads the byte into the data register.
// R10: data register keeps a read byte until next read or write.
// R11: cleared permit bits block writes and reads to the array.
// R12: write cycle timed by a timer asynchronous to the system clock; here a free-running divider of the core clock.
// R13: software never sets all four bits at once, nor both starts.
// R14: write order: permit, address and data, then write start.
// R15: read order: permit, address, start, then take data after start clears.
// R16: reset clears write permit and returns bank select to bank 0.
// R17: cycle end sets the store flag and the multi-function request flag.
// R18: completion request needs own enable and multi-function enable both set.
// R19: vector taken only with global, store, multi-function enables and stack not full.
// R20: servicing clears only the multi-function flag; software clears the store flag.
// R21: data register is eight bits read/write, reset zero.
// R22: software sets write start right after write permit, else no write.
// R23: write duration and read latency are design parameters.
package nvbc_pkg;
  localparam int unsigned NVBC_DEPTH = 32;
  localparam int unsigned NVBC_AW = 5;
  localparam logic [7:0] NVBC_CTRL_OFFSET = 8'h40;
  localparam logic NVBC_CTRL_BANK = 1'b1;
  localparam int unsigned NVBC_BIT_WPERMIT = 3;
  localparam int unsigned NVBC_BIT_WSTART = 2;
  localparam int unsigned NVBC_BIT_RPERMIT = 1;
  localparam int unsigned NVBC_BIT_RSTART = 0;
  localparam logic [7:0] NVBC_RESET_BYTE = 8'h00;
  localparam int unsigned NVBC_WRITE_NS = 2000;
  localparam int unsigned NVBC_CLK_NS = 20;
  localparam int unsigned NVBC_WRITE_CYCLES = (NVBC_WRITE_NS + NVBC_CLK_NS - 1) / NVBC_CLK_NS; // R23
  localparam int unsigned NVBC_READ_CYCLES = 2; // R23
  localparam int unsigned NVBC_TMR_DIV = 3;
  typedef enum logic [1:0] {
    NVBC_IDLE = 2'b00,
    NVBC_READ = 2'b01,
    NVBC_WRITE = 2'b10
  } nvbc_state_type;
endpackage : nvbc_pkg

// ===== hdl/nvbc_timer.sv
// free-running write timer, standing in for the store's own oscillator
// assumes the core clock; ticks are spaced unrelated to software activity
`timescale 1ns/1ps
`default_nettype none
module nvbc_timer
  import nvbc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // tick out
  output logic o_tick
);
  typedef struct packed {
    logic [3:0] div;
    logic tick;
  } nvbc_tmr_type;
  nvbc_tmr_type r;
  nvbc_tmr_type next_r;

  // free run, so a started write waits a varying number of clocks for its phase
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.div == 4'(NVBC_TMR_DIV)) begin
      next_r.div = 4'h0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_tick = r.tick;
endmodule : nvbc_timer
`default_nettype wire

// ===== verif/nvbc_ctrl_assertions.sv
// checker for the nonvolatile byte store controller
// assumes bind onto nvbc_ctrl, one core clock, i_ce held high
`timescale 1ns/1ps
`default_nettype none
module nvbc_ctrl_assertions (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // cpu side
  input wire logic i_window_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_nv_irq_enable,
  input wire logic i_mf_irq_enable,
  input wire logic i_global_irq_enable,
  input wire logic i_stack_full,
  input wire logic i_irq_serviced,
  input wire logic i_nv_flag_clear,
  // observed
  input wire logic [7:0] o_nv_byte_address,
  input wire logic [7:0] o_nv_byte_data,
  input wire logic [7:0] o_indirect_window_second,
  input wire logic o_window_hit,
  input wire logic o_nv_irq_flag,
  input wire logic o_mf_irq_flag,
  input wire logic o_irq_request,
  input wire logic o_vector_take,
  input wire logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  sequence s_ctl(logic [7:0] now, logic [7:0] val);
    i_window_wr && o_window_hit && !o_busy && o_indirect_window_second == now && i_wdata == val;
  endsequence
  sequence s_rd_run;
    o_busy [*2] ##1 !o_busy && o_indirect_window_second == 8'h02;
  endsequence
  property p_addr_top; o_nv_byte_address[7:5] == 3'h0; endproperty
  a_addr_top: assert property (p_addr_top) else $error("address top bits set");
  property p_ctl_top; o_indirect_window_second[7:4] == 4'h0; endproperty
  a_ctl_top: assert property (p_ctl_top) else $error("control top bits set");
  property p_rd_run; s_ctl(8'h02, 8'h03) |=> s_rd_run; endproperty
  a_rd_run: assert property (p_rd_run) else $error("read cycle length wrong");
  property p_wr_block; s_ctl(8'h00, 8'h04) |=> !o_busy && o_indirect_window_second == 8'h00; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write ran without permit");
  property p_data_hold; o_busy ##1 o_busy |-> $stable(o_nv_byte_data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data changed mid cycle");
  property p_end_flags; $fell(o_busy) |-> o_nv_irq_flag && o_mf_irq_flag; endproperty
  a_end_flags: assert property (p_end_flags) else $error("flags not set at end");
  property p_req; o_irq_request |-> i_nv_irq_enable && i_mf_irq_enable; endproperty
  a_req: assert property (p_req) else $error("request without enables");
  property p_vec; o_vector_take |-> i_global_irq_enable && o_irq_request && !i_stack_full; endproperty
  a_vec: assert property (p_vec) else $error("vector taken wrongly");
  property p_svc;
    i_irq_serviced && !i_nv_flag_clear && !o_busy && o_nv_irq_flag |=> !o_mf_irq_flag && o_nv_irq_flag;
  endproperty
  a_svc: assert property (p_svc) else $error("service cleared wrong flag");
endmodule : nvbc_ctrl_assertions
bind nvbc_ctrl nvbc_ctrl_assertions chk_u (.i_core_clk, .i_rst, .i_window_wr, .i_wdata,
  .i_nv_irq_enable, .i_mf_irq_enable, .i_global_irq_enable, .i_stack_full, .i_irq_serviced,
  .i_nv_flag_clear, .o_nv_byte_address, .o_nv_byte_data, .o_indirect_window_second,
  .o_window_hit, .o_nv_irq_flag, .o_mf_irq_flag, .o_irq_request, .o_vector_take, .o_busy);
`default_nettype wire

// ===== verif/nvbc_ctrl_tb.sv
// self-checking bench for the nonvolatile byte store controller
// assumes nvbc_ctrl and its package; inputs move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module nvbc_ctrl_tb;
  import nvbc_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_window_rd = 1'b1, i_ce = 1'b1;
  logic i_addr_wr = 1'b0, i_data_wr = 1'b0, i_bank_wr = 1'b0, i_pointer_wr = 1'b0, i_window_wr = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_nv_irq_enable = 1'b0, i_mf_irq_enable = 1'b0, i_global_irq_enable = 1'b0;
  logic i_stack_full = 1'b0, i_irq_serviced = 1'b0, i_nv_flag_clear = 1'b0;
  logic [7:0] o_nv_byte_address, o_nv_byte_data, o_bank_select, o_indirect_pointer_second;
  logic [7:0] o_indirect_window_second;
  logic o_window_hit, o_nv_irq_flag, o_mf_irq_flag, o_irq_request, o_vector_take, o_busy;
  int fail_count = 0, comparisons = 0, cycles = 0, a, d;
  int mem [32];
  always #10 i_core_clk = ~i_core_clk;
  nvbc_ctrl dut_u (.i_core_clk, .i_rst, .i_ce, .i_addr_wr, .i_data_wr, .i_wdata, .o_nv_byte_address,
    .o_nv_byte_data, .i_bank_wr, .i_pointer_wr, .o_bank_select, .o_indirect_pointer_second, .i_window_wr,
    .i_window_rd, .o_indirect_window_second, .o_window_hit, .i_nv_irq_enable, .i_mf_irq_enable,
    .i_global_irq_enable, .i_stack_full, .i_irq_serviced, .i_nv_flag_clear, .o_nv_irq_flag,
    .o_mf_irq_flag, .o_irq_request, .o_vector_take, .o_busy);
  ////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // write timer is about 400 clocks, so this leaves wide margin
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // idle cycle after each strobe so no strobe is set and cleared at once
  task automatic put(ref logic s, input logic [7:0] v);
    i_wdata = v;
    s = 1'b1;
    @(negedge i_core_clk);
    s = 1'b0;
    @(negedge i_core_clk);
  endtask : put
  task automatic wait_idle();
    for (int i = 0; i < 1000 && o_busy !== 1'b0; i++) @(negedge i_core_clk);
    chk("busy", 8'h00, {7'h0, o_busy});
  endtask : wait_idle
  task automatic nv_write(input int ad, input int dv);
    put(i_addr_wr, ad[7:0]);
    put(i_data_wr, dv[7:0]);
    put(i_window_wr, 8'h08);
    put(i_window_wr, 8'h0C);
    chk("wr busy", 8'h01, {7'h0, o_busy});
    put(i_addr_wr, 8'h00);
    wait_idle();
    chk("wr ctl", 8'h08, o_indirect_window_second);
    chk("addr", ad[7:0] & 8'h1F, o_nv_byte_address);
    mem[ad % 32] = dv;
    put(i_window_wr, 8'h00);
  endtask : nv_write
  task automatic nv_read(input int ad);
    put(i_addr_wr, ad[7:0]);
    put(i_window_wr, 8'h02);
    put(i_window_wr, 8'h03);
    wait_idle();
    chk("rd ctl", 8'h02, o_indirect_window_second);
    chk("rd data", mem[ad % 32][7:0], o_nv_byte_data);
    chk("nv flag", 8'h01, {7'h0, o_nv_irq_flag});
    chk("mf flag", 8'h01, {7'h0, o_mf_irq_flag});
    put(i_window_wr, 8'h00);
  endtask : nv_read
  initial begin
    void'($urandom(39935));
    repeat (12) @(negedge i_core_clk);
    i_rst = 1'b0;
    chk("addr rst", 8'h00, o_nv_byte_address);
    chk("data rst", 8'h00, o_nv_byte_data);
    chk("bank rst", 8'h00, o_bank_select);
    put(i_pointer_wr, 8'h40);
    chk("ptr", 8'h40, o_indirect_pointer_second);
    chk("hit bank0", 8'h00, {7'h0, o_window_hit});
    put(i_window_wr, 8'h08);
    put(i_bank_wr, 8'h01);
    chk("bank", 8'h01, o_bank_select);
    chk("ctl rst", 8'h00, o_indirect_window_second);
    put(i_window_wr, 8'h04);
    chk("wt no permit", 8'h00, o_indirect_window_second);
    put(i_window_wr, 8'h01);
    chk("rd no permit", 8'h00, o_indirect_window_second);
    chk("data kept", 8'h00, o_nv_byte_data);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(1, 30);
      d = $urandom_range(0, 255);
      nv_write(a, d);
      nv_read(a);
    end
    nv_write(255, 8'hA5);
    nv_read(31);
    for (int k = 0; k < 16; k++) begin
      {i_nv_irq_enable, i_mf_irq_enable, i_global_irq_enable, i_stack_full} = k[3:0];
      @(negedge i_core_clk);
      chk("req", {7'h0, k[3] & k[2]}, {7'h0, o_irq_request});
      chk("vector", {7'h0, k[3:1] == 3'b111 && !k[0]}, {7'h0, o_vector_take});
    end
    put(i_irq_serviced, 8'h00);
    chk("mf svc", 8'h00, {7'h0, o_mf_irq_flag});
    chk("nv svc", 8'h01, {7'h0, o_nv_irq_flag});
    put(i_nv_flag_clear, 8'h00);
    chk("nv clr", 8'h00, {7'h0, o_nv_irq_flag});
    // clears land on the very edge that ends a read: set must win
    put(i_window_wr, 8'h02);
    put(i_window_wr, 8'h03);
    {i_nv_flag_clear, i_irq_serviced} = 2'b11;
    @(negedge i_core_clk);
    {i_nv_flag_clear, i_irq_serviced} = 2'b00;
    chk("nv set wins", 8'h01, {7'h0, o_nv_irq_flag});
    chk("mf set wins", 8'h01, {7'h0, o_mf_irq_flag});
    chk("rd again", 8'hA5, o_nv_byte_data);
    put(i_window_wr, 8'h00);
    // clock enable low must freeze every register
    i_ce = 1'b0;
    put(i_nv_flag_clear, 8'h00);
    put(i_pointer_wr, 8'h00);
    chk("ce flag", 8'h01, {7'h0, o_nv_irq_flag});
    chk("ce ptr", 8'h40, o_indirect_pointer_second);
    i_ce = 1'b1;
    put(i_window_wr, 8'h08);
    chk("permit set", 8'h08, o_indirect_window_second);
    // mid-run reset: permits and bank drop, array keeps its bytes
    i_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    chk("bank rerst", 8'h00, o_bank_select);
    chk("addr rerst", 8'h00, o_nv_byte_address);
    put(i_pointer_wr, 8'h40);
    put(i_bank_wr, 8'h01);
    chk("permit rerst", 8'h00, o_indirect_window_second);
    nv_read(0);
    close_out();
  end
endmodule : nvbc_ctrl_tb
`default_nettype wire
